// [rtl/frm_fault_mgr.sv]
// Fault response manager: die-temperature lockouts, start-up rise timer,
// shared sync watchdog, per-channel fault responses, status and alert,
// and the bussed fault pins. Pins are sampled through two flops; the
// command, temperature and comparator inputs come from core-clock logic.
`timescale 1ns/1ps
// Notes on behaviour
// - Above 130C refuse memory commands, flag COMM_MEMORY_LOGIC_FAULT
// - Memory commands return only below 125C
// - PWM off above 160C until below 150C
// - No hardware shutdown for timing/external faults
// - Rise timer starts with soft-start, 10us steps
// - Rise timeout applies programmed timeout response
// - Sync low over 64us: hold 120ms, flag
// - Responses: ignore, retry, latch off
// - Retry soft-starts after interval if fault gone
// - Retry interval 120ms to 83s, 1ms steps
// - Latch off stops drive until off-on cycle
// - Run rise clears faults, optionally both channels
// - Clear-faults command clears all fault bits
// - Optional internal deglitch, bus faults unfiltered
// - Summary bit set from upper status nibble
// - Status bit holds alert until cleared
// - Alert released after alert-response address sent
// - Per-bit alert mask, promoted to summaries
// - Unsafe command while enabled sets unmaskable busy
// - Common and pin summaries never drive alert
// - Faults pull bus pin; 0xc0 channels shut down
module frm_fault_mgr
  import frm_pkg::*;
#(
  parameter int NCH = 2,
  parameter int MS_TICK_CYC_P = MS_TICK_CYC,
  parameter int SYNC_LOW_CYC_P = SYNC_LOW_CYC
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic [8:0] DIE_TEMP_I,
  input wire logic CMD_VALID_I,
  input wire logic [2:0] CMD_KIND_I,
  input wire logic ARA_DONE_I,
  input wire logic [STK_N-1:0] STATUS_W1C_I,
  input wire logic [STK_N-1:0] ALERT_MASK_I,
  input wire logic [NCH-1:0] RUN_PIN_I,
  input wire logic GLOBAL_CLR_I,
  input wire logic [NCH-1:0] TON_DELAY_DONE_I,
  input wire logic [15:0] TON_MAX_I,
  input wire logic [NCH-1:0] UV_OK_I,
  input wire logic [NCH-1:0] OC_I,
  input wire logic [NCH-1:0] INT_FAULT_I,
  input wire logic [NCH-1:0] DEGLITCH_EN_I,
  input wire logic [2*NCH-1:0] RESP_MODE_I,
  input wire logic [2*NCH-1:0] TON_RESP_I,
  input wire logic [16:0] RETRY_DELAY_I,
  input wire logic [NCH-1:0] PROPAGATE_MAP_I,
  input wire logic [8*NCH-1:0] FAULT_PIN_RESP_I,
  input wire logic [NCH-1:0] FAULT_BUS_I,
  input wire logic SHARED_SYNC_I,
  output logic [NCH-1:0] FAULT_BUS_O,
  output logic [NCH-1:0] FAULT_BUS_OE_O,
  output logic SHARED_SYNC_O,
  output logic SHARED_SYNC_OE_O,
  output logic [NCH-1:0] PWM_EN_O,
  output logic CMD_ACK_O,
  output logic CMD_NACK_O,
  output logic [7:0] STATUS_BYTE_O,
  output logic [15:0] STATUS_WORD_O,
  output logic [7:0] COMMON_SUMMARY_O,
  output logic ALERT_N_O
);
  localparam int MSW = $clog2(MS_TICK_CYC_P + 1);
  localparam int SLW = $clog2(SYNC_LOW_CYC_P + 1);
  localparam int RTW = $clog2(RISE_TICK_CYC + 1);

  function automatic logic is_clear_cmd(input logic [2:0] k);
    return (k == CMD_CLEAR) || (k == CMD_RESTORE) || (k == CMD_SOFT_RESET);
  endfunction : is_clear_cmd

  function automatic frm_state_e on_fault(input logic [1:0] resp, input frm_state_e stay);
    if (resp == RESP_IGNORE) return stay;
    if (resp == RESP_RETRY) return ST_WAIT;
    return ST_LATCH;
  endfunction : on_fault

  function automatic logic [16:0] clamp_retry(input logic [16:0] v);
    if (v < RETRY_MIN_MS) return RETRY_MIN_MS;
    if (v > RETRY_MAX_MS) return RETRY_MAX_MS;
    return v;
  endfunction : clamp_retry

  // Pin synchronisers: run pins, shared sync line and fault bus
  localparam int SYW = 2 * NCH + 1;
  logic [SYW-1:0] sy1_q;
  logic [SYW-1:0] sy2_q;
  logic [NCH-1:0] run_d_q;
  logic [NCH-1:0] run_s;
  logic [NCH-1:0] bus_s;
  logic sync_s;
  logic [NCH-1:0] run_rise;

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      sy1_q <= SYW'(SYNC_RST_VAL);
      sy2_q <= SYW'(SYNC_RST_VAL);
      run_d_q <= '0;
    end else begin
      sy1_q <= {FAULT_BUS_I, SHARED_SYNC_I, RUN_PIN_I};
      sy2_q <= sy1_q;
      run_d_q <= run_s;
    end
  end

  assign run_s = sy2_q[NCH-1:0];
  assign sync_s = sy2_q[NCH];
  assign bus_s = sy2_q[SYW-1:NCH+1];
  assign run_rise = run_s & ~run_d_q;

  // Tick generators
  logic [MSW-1:0] ms_cnt_q;
  logic [RTW-1:0] rt_cnt_q;
  logic ms_tick;
  logic rise_tick;

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      ms_cnt_q <= '0;
      rt_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + MSW'(1);
      rt_cnt_q <= rise_tick ? '0 : rt_cnt_q + RTW'(1);
    end
  end

  assign ms_tick = (ms_cnt_q == MSW'(MS_TICK_CYC_P - 1));
  assign rise_tick = (rt_cnt_q == RTW'(RISE_TICK_CYC - 1));

  // Die temperature hysteresis
  logic nvm_lock_q;
  logic pwm_hot_q;
  logic temp_ev;

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      nvm_lock_q <= 1'b0;
      pwm_hot_q <= 1'b0;
    end else begin
      if (DIE_TEMP_I > TEMP_NVM_LOCK) begin
        nvm_lock_q <= 1'b1;
      end else if (DIE_TEMP_I < TEMP_NVM_UNLOCK) begin
        nvm_lock_q <= 1'b0;
      end
      if (DIE_TEMP_I > TEMP_PWM_OFF) begin
        pwm_hot_q <= 1'b1;
      end else if (DIE_TEMP_I < TEMP_PWM_ON) begin
        pwm_hot_q <= 1'b0;
      end
    end
  end

  assign temp_ev = ((DIE_TEMP_I > TEMP_NVM_LOCK) && !nvm_lock_q) ||
                   ((DIE_TEMP_I > TEMP_PWM_OFF) && !pwm_hot_q);

  // Command screening
  logic clear_all;
  logic cmd_cml;
  logic cmd_busy;
  logic [NCH-1:0] ch_enabled;

  assign clear_all = CMD_VALID_I && is_clear_cmd(CMD_KIND_I);
  assign cmd_cml = CMD_VALID_I && ((CMD_KIND_I == CMD_INVALID) ||
                   ((CMD_KIND_I == CMD_NVM) && nvm_lock_q));
  assign cmd_busy = CMD_VALID_I && (CMD_KIND_I == CMD_UNSAFE) && (|ch_enabled);

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      CMD_ACK_O <= 1'b0;
      CMD_NACK_O <= 1'b0;
    end else begin
      CMD_NACK_O <= cmd_cml || cmd_busy;
      CMD_ACK_O <= CMD_VALID_I && !cmd_cml && !cmd_busy;
    end
  end

  // Shared sync line watchdog
  logic [SLW-1:0] low_cnt_q;
  logic [7:0] hold_q;
  logic sync_oe_q;
  logic stuck_q;
  logic wd_trip;

  assign wd_trip = !sync_oe_q && !sync_s && (low_cnt_q == SLW'(SYNC_LOW_CYC_P));

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      low_cnt_q <= '0;
      hold_q <= '0;
      sync_oe_q <= 1'b0;
    end else begin
      if (sync_oe_q || sync_s) begin
        low_cnt_q <= '0;
      end else if (!wd_trip) begin
        low_cnt_q <= low_cnt_q + SLW'(1);
      end
      if (wd_trip) begin
        // One extra tick so the hold is never shorter than the full time
        hold_q <= 8'(SYNC_HOLD_MS + 1);
        sync_oe_q <= 1'b1;
      end else if (sync_oe_q && ms_tick) begin
        hold_q <= hold_q - 8'h01;
        if (hold_q == 8'h01) begin
          sync_oe_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      stuck_q <= 1'b0;
    end else begin
      stuck_q <= wd_trip || (stuck_q && !clear_all);
    end
  end

  // Per-channel fault response
  logic [NCH-1:0] ch_run;
  logic [NCH-1:0] pin_drv;
  logic [NCH-1:0] bus_shut;
  logic [NCH-1:0] flt_ev;
  logic [NCH-1:0] ton_ev;
  logic [NCH-1:0] ch_clr;
  logic [STK_N-1:0] stk_q;

  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      frm_state_e st_q;
      frm_state_e st_d;
      logic [DEGLITCH_CYC-1:0] dg_q;
      logic flt;
      logic rise_ld;
      logic rise_done;
      logic retry_ld;
      logic retry_done;
      logic timeout;
      logic pin_hold_q;
      logic [1:0] resp;
      logic [1:0] ton_resp;

      assign resp = RESP_MODE_I[2*c +: 2];
      assign ton_resp = TON_RESP_I[2*c +: 2];

      always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
          dg_q <= '0;
        end else begin
          dg_q <= {dg_q[DEGLITCH_CYC-2:0], INT_FAULT_I[c]};
        end
      end

      // Deglitch costs latency, so it is left to software per channel
      assign flt = DEGLITCH_EN_I[c] ? &dg_q : INT_FAULT_I[c];
      assign timeout = rise_done && (!UV_OK_I[c] || OC_I[c]);

      always_comb begin
        st_d = st_q;
        rise_ld = 1'b0;
        retry_ld = 1'b0;
        unique case (st_q)
          ST_OFF: begin
            if (TON_DELAY_DONE_I[c]) begin
              st_d = ST_RISE;
              rise_ld = 1'b1;
            end
          end
          ST_RISE: begin
            if (flt) begin
              st_d = on_fault(resp, ST_RISE);
            end else if (timeout) begin
              st_d = on_fault(ton_resp, ST_ON);
            end else if (UV_OK_I[c] && !OC_I[c]) begin
              st_d = ST_ON;
            end
          end
          ST_ON: begin
            if (flt) begin
              st_d = on_fault(resp, ST_ON);
            end
          end
          ST_WAIT: begin
            if (retry_done && !flt) begin
              st_d = ST_RISE;
              rise_ld = 1'b1;
            end else if (retry_done) begin
              retry_ld = 1'b1;
            end
          end
          ST_LATCH: begin
            st_d = ST_LATCH;
          end
        endcase
        if (st_d == ST_WAIT && st_q != ST_WAIT) begin
          retry_ld = 1'b1;
        end
        if (!run_s[c]) begin
          st_d = ST_OFF;
          rise_ld = 1'b0;
          retry_ld = 1'b0;
        end
      end

      always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
          st_q <= ST_OFF;
        end else begin
          st_q <= st_d;
        end
      end

      always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
          pin_hold_q <= 1'b0;
        end else if (st_d == ST_LATCH && st_q != ST_LATCH) begin
          pin_hold_q <= 1'b1;
        end else if (clear_all || ch_clr[c] || |STATUS_W1C_I[STK_CH_BASE+2*c +: 2]) begin
          pin_hold_q <= 1'b0;
        end
      end

      frm_timer #(.W(16)) u_rise (
        .clk_i(CORE_CLK_I),
        .rst_i(RST_I),
        .load_i(rise_ld),
        .stop_i(st_q != ST_RISE),
        .tick_i(rise_tick),
        .val_i(TON_MAX_I),
        .done_o(rise_done)
      );

      // Interval steps on a free 1 ms tick, so it may end up to 1 ms early
      frm_timer #(.W(17)) u_retry (
        .clk_i(CORE_CLK_I),
        .rst_i(RST_I),
        .load_i(retry_ld),
        .stop_i(st_q != ST_WAIT),
        .tick_i(ms_tick),
        .val_i(clamp_retry(RETRY_DELAY_I)),
        .done_o(retry_done)
      );

      assign ch_run[c] = (st_q == ST_RISE) || (st_q == ST_ON);
      assign ch_enabled[c] = (st_q != ST_OFF);
      assign pin_drv[c] = PROPAGATE_MAP_I[c] && ((st_q == ST_WAIT) || pin_hold_q);
      // Bus faults act only through the programmed pin response
      assign bus_shut[c] = !bus_s[c] &&
                           (FAULT_PIN_RESP_I[8*c +: 8] == FAULT_PIN_SHUTDOWN);
      assign flt_ev[c] = flt && ch_enabled[c];
      assign ton_ev[c] = timeout && (st_q == ST_RISE);
      assign ch_clr[c] = run_rise[c] || (GLOBAL_CLR_I && |run_rise);
    end
  endgenerate

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      PWM_EN_O <= '0;
      FAULT_BUS_OE_O <= '0;
      FAULT_BUS_O <= '0;
      SHARED_SYNC_OE_O <= 1'b0;
      SHARED_SYNC_O <= 1'b0;
    end else begin
      PWM_EN_O <= ch_run & ~bus_shut & {NCH{!pwm_hot_q}};
      FAULT_BUS_OE_O <= pin_drv;
      FAULT_BUS_O <= '0;
      SHARED_SYNC_OE_O <= sync_oe_q;
      SHARED_SYNC_O <= 1'b0;
    end
  end

  // Sticky status bits, set wins over clear
  logic [STK_N-1:0] set_v;
  logic [STK_N-1:0] clr_v;
  logic [STK_N-1:0] new_set;
  logic [STK_N-1:0] mask_eff;
  logic alert_clr;
  logic alert_q;

  always_comb begin
    set_v = '0;
    clr_v = STATUS_W1C_I | {STK_N{clear_all}};
    set_v[STK_CML] = cmd_cml;
    set_v[STK_TEMP] = temp_ev;
    set_v[STK_BUSY] = cmd_busy;
    for (int i = 0; i < NCH; i++) begin
      set_v[STK_CH_BASE + 2*i] = flt_ev[i];
      set_v[STK_CH_BASE + 2*i + 1] = ton_ev[i];
      clr_v[STK_CH_BASE + 2*i] = clr_v[STK_CH_BASE + 2*i] | ch_clr[i];
      clr_v[STK_CH_BASE + 2*i + 1] = clr_v[STK_CH_BASE + 2*i + 1] | ch_clr[i];
    end
    mask_eff = ALERT_MASK_I;
    mask_eff[STK_BUSY] = 1'b0;
  end

  assign new_set = set_v & ~stk_q;
  assign alert_clr = clear_all || (|STATUS_W1C_I) || ARA_DONE_I || (|run_rise);

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      stk_q <= '0;
      alert_q <= 1'b0;
    end else begin
      stk_q <= (stk_q & ~clr_v) | set_v;
      // Per-bit mask also masks the summary bit once all its sources are masked
      alert_q <= (|(new_set & ~mask_eff)) || (alert_q && !alert_clr);
    end
  end

  logic [15:0] word_d;

  always_comb begin
    word_d = '0;
    word_d[SW_CML] = stk_q[STK_CML];
    word_d[SW_TEMP] = stk_q[STK_TEMP];
    word_d[SW_BUSY] = stk_q[STK_BUSY];
    word_d[SW_OFF] = |(~PWM_EN_O);
    word_d[SW_VOUT] = |stk_q[STK_N-1:STK_CH_BASE];
    word_d[SW_NOA] = |word_d[15:12];
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      STATUS_WORD_O <= '0;
      STATUS_BYTE_O <= '0;
      COMMON_SUMMARY_O <= '0;
      ALERT_N_O <= 1'b1;
    end else begin
      STATUS_WORD_O <= word_d;
      STATUS_BYTE_O <= word_d[7:0];
      // Summary flags are informative only and stay out of the alert path
      COMMON_SUMMARY_O <= {5'h00, pwm_hot_q, nvm_lock_q, stuck_q};
      ALERT_N_O <= !alert_q;
    end
  end
endmodule : frm_fault_mgr

// [rtl/frm_pkg.sv]
// Constants, encodings and timing counts for the fault response manager.
// Assumes a 100 MHz core clock; all users import the whole package.
package frm_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RISE_RES_NS = 10000;
  localparam int RISE_TICK_CYC = (RISE_RES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_STEP_NS = 1000000;
  localparam int MS_TICK_CYC = RETRY_STEP_NS / CLK_PERIOD_NS;
  localparam int SYNC_LOW_NS = 64000;
  localparam int SYNC_LOW_CYC = SYNC_LOW_NS / CLK_PERIOD_NS;
  localparam int SYNC_HOLD_MS = 120;
  localparam logic [16:0] RETRY_MIN_MS = 17'h00078;
  localparam logic [16:0] RETRY_MAX_MS = 17'h14438;
  localparam int DEGLITCH_CYC = 3;

  localparam logic [8:0] TEMP_NVM_LOCK = 9'h082;
  localparam logic [8:0] TEMP_NVM_UNLOCK = 9'h07d;
  localparam logic [8:0] TEMP_PWM_OFF = 9'h0a0;
  localparam logic [8:0] TEMP_PWM_ON = 9'h096;
  localparam logic [8:0] TEMP_NVM_ADVISE = 9'h055;

  localparam logic [7:0] FAULT_PIN_SHUTDOWN = 8'hc0;
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_RETRY = 2'h1;

  localparam int STK_CML = 0;
  localparam int STK_TEMP = 1;
  localparam int STK_BUSY = 2;
  localparam int STK_CH_BASE = 3;
  localparam int STK_N = 7;

  localparam int SW_NOA = 0;
  localparam int SW_CML = 1;
  localparam int SW_TEMP = 2;
  localparam int SW_OFF = 6;
  localparam int SW_BUSY = 7;
  localparam int SW_VOUT = 15;

  localparam int CS_STUCK = 0;
  localparam int CS_NVM_LOCK = 1;
  localparam int CS_PWM_HOT = 2;

  localparam logic [4:0] SYNC_RST_VAL = 5'h1c;

  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_CLEAR = 3'h1,
    CMD_RESTORE = 3'h2,
    CMD_SOFT_RESET = 3'h3,
    CMD_NVM = 3'h4,
    CMD_UNSAFE = 3'h5,
    CMD_PLAIN = 3'h6,
    CMD_INVALID = 3'h7
  } frm_cmd_e;

  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_RISE = 5'h02,
    ST_ON = 5'h04,
    ST_WAIT = 5'h08,
    ST_LATCH = 5'h10
  } frm_state_e;
endpackage : frm_pkg

// [rtl/frm_timer.sv]
// One-shot down counter advanced by an external tick strobe.
// Assumes tick_i is a one-cycle strobe from the same clock domain.
`timescale 1ns/1ps
module frm_timer #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic stop_i,
  input wire logic tick_i,
  input wire logic [W-1:0] val_i,
  output logic done_o
);
  logic [W-1:0] cnt_q;
  logic arm_q;
  logic done_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      arm_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (load_i) begin
        cnt_q <= val_i;
        arm_q <= 1'b1;
      end else if (stop_i) begin
        arm_q <= 1'b0;
      end else if (arm_q && tick_i) begin
        if (cnt_q <= W'(1)) begin
          arm_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - W'(1);
        end
      end
    end
  end

  assign done_o = done_q;
endmodule : frm_timer

// [verif/frm_fault_mgr_properties.sv]
// Concurrent checks on the fault response manager top-level ports.
// Bound from the bench top; a single core clock domain, sync reset.
`timescale 1ns/1ps
module frm_fault_mgr_properties
  import frm_pkg::*;
#(
  parameter int NCH = 2,
  parameter int SYNC_LOW_CYC_P = SYNC_LOW_CYC
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic [8:0] DIE_TEMP_I,
  input wire logic CMD_VALID_I,
  input wire logic [2:0] CMD_KIND_I,
  input wire logic SHARED_SYNC_I,
  input wire logic SHARED_SYNC_OE_O,
  input wire logic [NCH-1:0] PWM_EN_O,
  input wire logic CMD_ACK_O,
  input wire logic CMD_NACK_O,
  input wire logic [7:0] STATUS_BYTE_O,
  input wire logic [15:0] STATUS_WORD_O,
  input wire logic [7:0] COMMON_SUMMARY_O,
  input wire logic ALERT_N_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  // Raw low time of the shared line, saturating so it never wraps to a false short count
  logic [15:0] low_cnt_q;
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || SHARED_SYNC_I) begin
      low_cnt_q <= 16'h0000;
    end else if (low_cnt_q != 16'hffff) begin
      low_cnt_q <= low_cnt_q + 16'h0001;
    end
  end
  cmd_answer_a: assert property (CMD_VALID_I |=> CMD_ACK_O != CMD_NACK_O)
    else $error("command answer missing or doubled");
  invalid_nack_a: assert property (CMD_VALID_I && CMD_KIND_I == 3'h7 |=> CMD_NACK_O)
    else $error("invalid command not refused");
  lock_refuse_a: assert property ((DIE_TEMP_I > TEMP_NVM_LOCK)[*3] ##0
    (CMD_VALID_I && CMD_KIND_I == 3'h4) |=> CMD_NACK_O) else $error("memory cmd taken hot");
  kept_cmds_a: assert property (CMD_VALID_I && CMD_KIND_I inside {3'h1, 3'h2, 3'h3, 3'h6}
    |=> CMD_ACK_O) else $error("always-allowed command refused");
  unlock_a: assert property ((DIE_TEMP_I < TEMP_NVM_UNLOCK)[*3] ##0
    (CMD_VALID_I && CMD_KIND_I == 3'h4) |=> CMD_ACK_O) else $error("memory cmd refused cool");
  pwm_hot_a: assert property ((DIE_TEMP_I > TEMP_PWM_OFF)[*4] |-> PWM_EN_O == '0)
    else $error("drive left on above shutdown temperature");
  busy_alert_a: assert property (CMD_VALID_I && CMD_KIND_I == 3'h5 && PWM_EN_O != '0
    |=> CMD_NACK_O ##1 !ALERT_N_O) else $error("busy refusal without alert");
  noa_summary_a: assert property (STATUS_WORD_O[SW_NOA] == |STATUS_WORD_O[15:12])
    else $error("summary bit disagrees with upper nibble");
  byte_copy_a: assert property (STATUS_BYTE_O == STATUS_WORD_O[7:0])
    else $error("status byte differs from word low byte");
  alert_cause_a: assert property (!ALERT_N_O |-> (STATUS_WORD_O & 16'hffbf) != 16'h0000)
    else $error("alert low with no status bit set");
  sync_wait_a: assert property ($rose(SHARED_SYNC_OE_O) |-> low_cnt_q >= SYNC_LOW_CYC_P)
    else $error("shared line held before low limit");
  sync_flag_a: assert property ($rose(SHARED_SYNC_OE_O) |-> ##[0:2] COMMON_SUMMARY_O[CS_STUCK])
    else $error("stuck flag not set");
endmodule : frm_fault_mgr_properties

// [verif/frm_fault_mgr_tb_top.sv]
// Directed bench for the fault response manager with peers on shared lines.
// Short ms tick and sync limit keep retry and hold times inside the run.
`timescale 1ns/1ps
module frm_fault_mgr_tb_top
  import frm_pkg::*;
();
  localparam int MS = 50;
  logic clk = 1'b0, rst = 1'b1, cv = 1'b0, ara = 1'b0, ps = 1'b0, gclr = 1'b0;
  logic [8:0] temp = 9'h019;
  logic [2:0] kind = 3'h0;
  logic [6:0] w1c = 7'h00, amask = 7'h00;
  logic [1:0] run = 2'b00, tdone = 2'b00, uv = 2'b11, ifl = 2'b00, dg = 2'b00, oc = 2'b00;
  logic [1:0] map = 2'b00, pf = 2'b00, fbo, fboe, pwm, fw;
  logic [3:0] rmode = 4'h0, tresp = 4'h0;
  logic [15:0] tmax = 16'hffff, fpr = 16'h0000, sword;
  logic [16:0] rdly = 17'h00078;
  logic so, soe, ack, nack, alert_n, sw;
  logic [7:0] sbyte, comm;
  int num_errors = 0;
  int n_tests = 0;
  int n;
  always #5 clk = ~clk;
  frm_fault_mgr #(.MS_TICK_CYC_P(MS), .SYNC_LOW_CYC_P(20)) u_frm_fault_mgr (
    .CORE_CLK_I(clk), .RST_I(rst), .DIE_TEMP_I(temp), .CMD_VALID_I(cv), .CMD_KIND_I(kind),
    .ARA_DONE_I(ara), .STATUS_W1C_I(w1c), .ALERT_MASK_I(amask), .RUN_PIN_I(run),
    .GLOBAL_CLR_I(gclr), .TON_DELAY_DONE_I(tdone), .TON_MAX_I(tmax), .UV_OK_I(uv),
    .OC_I(oc), .INT_FAULT_I(ifl), .DEGLITCH_EN_I(dg), .RESP_MODE_I(rmode),
    .TON_RESP_I(tresp), .RETRY_DELAY_I(rdly), .PROPAGATE_MAP_I(map),
    .FAULT_PIN_RESP_I(fpr), .FAULT_BUS_I(fw), .SHARED_SYNC_I(sw), .FAULT_BUS_O(fbo),
    .FAULT_BUS_OE_O(fboe), .SHARED_SYNC_O(so), .SHARED_SYNC_OE_O(soe), .PWM_EN_O(pwm),
    .CMD_ACK_O(ack), .CMD_NACK_O(nack), .STATUS_BYTE_O(sbyte), .STATUS_WORD_O(sword),
    .COMMON_SUMMARY_O(comm), .ALERT_N_O(alert_n));
  frm_peer_model u_frm_peer_model (
    .dut_fault_i(fbo), .dut_fault_oe_i(fboe), .dut_sync_i(so), .dut_sync_oe_i(soe),
    .peer_fault_pull_i(pf), .peer_sync_pull_i(ps), .fault_wire_o(fw), .sync_wire_o(sw));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  task automatic cmd(input logic [2:0] k, input logic ok);
    @(posedge clk);
    cv <= 1'b1;
    kind <= k;
    @(posedge clk);
    cv <= 1'b0;
    #1;
    check(ack, ok);
    check(nack, !ok);
  endtask : cmd
  task automatic wait_pwm(input int ch, input logic v, input int lim);
    #1;
    n = 0;
    while (pwm[ch] !== v && n < lim) begin
      step(1);
      n++;
    end
    check(pwm[ch], v);
    if (pwm[ch] !== v) finish_test();
  endtask : wait_pwm
  task automatic start_ch(input int ch);
    @(posedge clk);
    run[ch] <= 1'b1;
    repeat (4) @(posedge clk);
    tdone[ch] <= 1'b1;
    @(posedge clk);
    tdone[ch] <= 1'b0;
    #1;
    wait_pwm(ch, 1'b1, 4);
  endtask : start_ch
  task automatic pulse_w1c();
    @(posedge clk);
    w1c <= 7'h01;
    @(posedge clk);
    w1c <= 7'h00;
    step(2);
  endtask : pulse_w1c
  task automatic set_temp(input logic [8:0] t);
    @(posedge clk);
    temp <= t;
    step(3);
  endtask : set_temp
  task automatic s_cmds();
    for (int k = 1; k < 8; k++) begin
      cmd(k[2:0], k != 7);
    end
    step(1);
    check(alert_n, 1'b0);
    @(posedge clk);
    ara <= 1'b1;
    @(posedge clk);
    ara <= 1'b0;
    step(2);
    check(alert_n, 1'b1);
    pulse_w1c();
    check(sword[SW_CML], 1'b0);
    @(posedge clk);
    amask <= 7'h01;
    cmd(3'h7, 1'b0);
    step(1);
    check(alert_n, 1'b1);
    check(sword[SW_CML], 1'b1);
    set_temp(9'h083);
    cmd(3'h4, 1'b0);
    cmd(3'h2, 1'b1);
    cmd(3'h3, 1'b1);
    check(comm[CS_NVM_LOCK], 1'b1);
    set_temp(9'h07f);
    cmd(3'h4, 1'b0);
    step(1);
    check(sword[SW_CML], 1'b1);
    set_temp(9'h07c);
    cmd(3'h4, 1'b1);
    set_temp(9'h03c);
    @(posedge clk) amask <= 7'h00;
    cmd(3'h4, 1'b1);
    cmd(3'h1, 1'b1);
    step(2);
    check(sword & 16'hffbf, 16'h0000);
  endtask : s_cmds
  task automatic s_sync();
    @(posedge clk);
    ps <= 1'b1;
    repeat (30) @(posedge clk);
    ps <= 1'b0;
    step(1);
    check({soe, sw, comm[CS_STUCK], alert_n}, 4'b1011);
    n = 0;
    while (soe === 1'b1 && n < 130 * MS) begin
      step(1);
      n++;
    end
    check(n >= 118 * MS && n <= 122 * MS, 1'b1);
    cmd(3'h1, 1'b1);
    step(2);
    check(comm[CS_STUCK], 1'b0);
  endtask : s_sync
  task automatic s_chan();
    start_ch(0);
    @(posedge clk);
    amask <= 7'h7f;
    cmd(3'h5, 1'b0);
    step(1);
    check({alert_n, pwm[0]}, 2'b01);
    set_temp(9'h0a1);
    wait_pwm(0, 1'b0, 6);
    @(posedge clk);
    temp <= 9'h097;
    step(6);
    check({alert_n, pwm[0]}, 2'b00);
    @(posedge clk);
    temp <= 9'h095;
    amask <= 7'h00;
    wait_pwm(0, 1'b1, 8);
    @(posedge clk);
    ifl <= 2'b01;
    step(4);
    check(pwm[0], 1'b1);
    check({sword[SW_VOUT], sword[SW_NOA], sbyte[SW_NOA]}, 3'b111);
    @(posedge clk);
    ifl <= 2'b00;
    pf <= 2'b01;
    step(6);
    check(pwm[0], 1'b1);
    @(posedge clk);
    fpr <= {8'h00, FAULT_PIN_SHUTDOWN};
    dg <= 2'b01;
    wait_pwm(0, 1'b0, 4);
    @(posedge clk);
    pf <= 2'b00;
    dg <= 2'b00;
    wait_pwm(0, 1'b1, 6);
    cmd(3'h1, 1'b1);
  endtask : s_chan
  task automatic s_latch();
    @(posedge clk);
    rmode <= 4'h2;
    map <= 2'b01;
    dg <= 2'b01;
    ifl <= 2'b01;
    @(posedge clk);
    ifl <= 2'b00;
    step(4);
    check({pwm[0], fboe[0]}, 2'b10);
    @(posedge clk);
    dg <= 2'b00;
    ifl <= 2'b01;
    @(posedge clk);
    ifl <= 2'b00;
    wait_pwm(0, 1'b0, 4);
    step(40);
    check({pwm[0], fboe[0], fw[0]}, 3'b010);
    cmd(3'h1, 1'b1);
    step(2);
    check({pwm[0], fboe[0]}, 2'b00);
    @(posedge clk);
    run[0] <= 1'b0;
    repeat (5) @(posedge clk);
    start_ch(0);
  endtask : s_latch
  task automatic s_retry();
    @(posedge clk);
    rmode <= 4'h1;
    rdly <= 17'h00005;
    fpr <= 16'h0000;
    ifl <= 2'b01;
    wait_pwm(0, 1'b0, 4);
    step(125 * MS);
    check({pwm[0], fboe[0]}, 2'b01);
    @(posedge clk);
    ifl <= 2'b00;
    wait_pwm(0, 1'b1, 122 * MS);
    check(n >= 110 * MS && n <= 118 * MS, 1'b1);
    check(fboe[0], 1'b0);
  endtask : s_retry
  task automatic s_tmo();
    @(posedge clk);
    tmax <= 16'h0002;
    tresp <= 4'h8;
    uv <= 2'b01;
    gclr <= 1'b1;
    start_ch(1);
    check(sword[SW_VOUT], 1'b0);
    wait_pwm(1, 1'b0, 2100);
    check(n >= 995 && n <= 2005, 1'b1);
    step(20);
    check(pwm[1], 1'b0);
    @(posedge clk);
    run[1] <= 1'b0;
    uv <= 2'b11;
    oc <= 2'b10;
    repeat (5) @(posedge clk);
    start_ch(1);
    wait_pwm(1, 1'b0, 2100);
  endtask : s_tmo
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    step(2);
    s_cmds();
    s_sync();
    s_chan();
    s_latch();
    s_retry();
    s_tmo();
    finish_test();
  end
endmodule : frm_fault_mgr_tb_top
bind frm_fault_mgr frm_fault_mgr_properties #(.NCH(NCH), .SYNC_LOW_CYC_P(SYNC_LOW_CYC_P))
  u_frm_fault_mgr_properties (
  .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .DIE_TEMP_I(DIE_TEMP_I),
  .CMD_VALID_I(CMD_VALID_I), .CMD_KIND_I(CMD_KIND_I), .SHARED_SYNC_I(SHARED_SYNC_I),
  .SHARED_SYNC_OE_O(SHARED_SYNC_OE_O), .PWM_EN_O(PWM_EN_O), .CMD_ACK_O(CMD_ACK_O),
  .CMD_NACK_O(CMD_NACK_O), .STATUS_BYTE_O(STATUS_BYTE_O), .STATUS_WORD_O(STATUS_WORD_O),
  .COMMON_SUMMARY_O(COMMON_SUMMARY_O), .ALERT_N_O(ALERT_N_O));

// [verif/frm_peer_model.sv]
// Peer controllers sharing the bussed fault pins and the sync line.
// Open-drain wires with pull-ups; the bench tells the peers when to pull, and the free share clock also pulls the sync line.
`timescale 1ns/1ps
module frm_peer_model (
  input wire logic [1:0] dut_fault_i,
  input wire logic [1:0] dut_fault_oe_i,
  input wire logic dut_sync_i,
  input wire logic dut_sync_oe_i,
  input wire logic [1:0] peer_fault_pull_i,
  input wire logic peer_sync_pull_i,
  output logic [1:0] fault_wire_o,
  output logic sync_wire_o
);
  // Released lines return high through the pull-up, never keeping a stale level
  assign fault_wire_o = (dut_fault_i | ~dut_fault_oe_i) & ~peer_fault_pull_i;
  // Peers run the share clock freely; its low phase stays well under the watchdog limit
  logic share_clk = 1'b1;
  always #80 share_clk = ~share_clk;
  assign sync_wire_o = (dut_sync_i | ~dut_sync_oe_i) & ~peer_sync_pull_i & share_clk;
endmodule : frm_peer_model
